// >>> design/bkl_pkg.sv
package bkl_pkg;

  // ==========================================================================
  // Bus addressing and timing.
  // ==========================================================================
  localparam logic [6:0]  ADDR_SEL_LOW    = 7'h36;
  localparam logic [6:0]  ADDR_SEL_HIGH   = 7'h38;
  localparam int          CLK_PERIOD_PS   = 4000;
  localparam int          WAIT_TIME_US    = 1000;
  localparam int          WAIT_CYCLES     = (WAIT_TIME_US * 1000000 +
                                             CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Half a link clock period; 500 ns keeps a whole transfer short.
  localparam int          SCL_HALF_CYCLES = 125;

  // ==========================================================================
  // Register map.
  // ==========================================================================
  localparam logic [7:0] REG_CONTROL       = 8'h00;
  localparam logic [7:0] REG_CONFIGURATION = 8'h01;
  localparam logic [7:0] REG_BOOST         = 8'h02;
  localparam logic [7:0] REG_BRIGHT_A      = 8'h03;
  localparam logic [7:0] REG_BRIGHT_B      = 8'h04;
  localparam logic [7:0] REG_CURRENT_A     = 8'h05;
  localparam logic [7:0] REG_CURRENT_B     = 8'h06;
  localparam logic [7:0] REG_ONOFF_RAMP    = 8'h07;
  localparam logic [7:0] REG_RUN_RAMP      = 8'h08;
  localparam logic [7:0] REG_INT_STATUS    = 8'h09;
  localparam logic [7:0] REG_INT_ENABLE    = 8'h0A;
  localparam logic [7:0] REG_FAULT_STATUS  = 8'h0B;
  localparam logic [7:0] REG_SW_RESET      = 8'h0F;
  localparam logic [7:0] REG_PWM_LOW       = 8'h12;
  localparam logic [7:0] REG_PWM_HIGH      = 8'h13;
  localparam logic [7:0] REG_REVISION      = 8'h1F;
  localparam logic [7:0] REG_FILTER        = 8'h50;

  localparam logic [7:0] RST_CONTROL       = 8'hC0;
  localparam logic [7:0] RST_CONFIGURATION = 8'h18;
  localparam logic [7:0] RST_BOOST         = 8'h38;
  localparam logic [7:0] RST_CURRENT       = 8'h1F;
  localparam logic [7:0] RST_ZERO          = 8'h00;
  // Arbitrary neutral revision value.
  localparam logic [7:0] REVISION_VALUE    = 8'h5A;

  localparam int CTL_SLEEP_CMD    = 7;
  localparam int CTL_SLEEP_STATUS = 6;
  localparam int CTL_STRING_A_EN  = 2;
  localparam int CTL_STRING_B_EN  = 1;
  localparam logic [7:0] CTL_WRITE_MASK = 8'h9F;
  localparam int SWRST_BIT        = 0;

  // Host controller command port offsets.
  localparam logic [1:0] HOST_REG_CMD    = 2'h0;
  localparam logic [1:0] HOST_REG_STATUS = 2'h1;
  localparam logic [1:0] HOST_REG_RDATA  = 2'h2;

endpackage

// >>> design/bkl_if.sv
`timescale 1ns/100ps
// Two open-drain wires; each line is high unless some party pulls it low.
interface bkl_if;
  logic scl_host_oe;
  logic sda_host_oe;
  logic sda_dev_oe;
  logic scl;
  logic sda;

  // Wired-AND resolution with the pull-up.
  assign scl = ~scl_host_oe;
  assign sda = ~(sda_host_oe | sda_dev_oe);

  modport device (input scl, input sda, output sda_dev_oe);
  modport host   (input scl, input sda, output scl_host_oe,
                  output sda_host_oe);
endinterface

// >>> design/bkl_device.sv
`timescale 1ns/100ps
// Summary of operation
// - Data changes only while clock is low.
// - Data falling with clock high is start.
// - Data rising with clock high is stop.
// - Only the controller makes start and stop.
// - Bus busy from start until stop.
// - Repeated start restarts address reception.
// - Bytes are eight bits, MSB first.
// - Acknowledge slot follows every byte.
// - Controller clocks ack and releases data.
// - Device pulls data low on ninth pulse.
// - First byte: seven-bit address plus direction.
// - Direction zero writes, one reads.
// - Address 0x36 select low, 0x38 high.
// - Second byte index, third byte data.
// - Registers reset to listed defaults.
// - Software writes undefined bits as zero.
// - Control bit 7 requests sleep.
// - Control bit 6 reads sleep status.
// - Control bits 2,1 enable strings A,B.
// - No acknowledge for 1ms after reset.
// - Brightness writes ignored while asleep.
module bkl_device
  import bkl_pkg::*;
#(
  parameter int WAIT_COUNT = WAIT_CYCLES
) (
  input  wire logic  I_REF_CLK,
  input  wire logic  I_RST_N,
  input  wire logic  I_ADDR_SEL,
  input  wire logic  I_HARDWARE_ENABLE_PIN,
  bkl_if.device      bus,
  output logic       O_STRING_A_OUTPUT_ENABLE,
  output logic       O_STRING_B_OUTPUT_ENABLE,
  output logic       O_SLEEP,
  output logic       O_BUS_BUSY
);

  typedef enum logic [2:0] {
    BKLD_IDLE = 3'b000,
    BKLD_BITS = 3'b001,
    BKLD_ACK  = 3'b011,
    BKLD_SEND = 3'b010,
    BKLD_RACK = 3'b110
  } bkld_state_t;

  typedef struct packed {
    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
    logic        scl_d;
    logic        sda_d;
    logic        hardware_enable_pin_q;
    logic [19:0] wait_cnt;
    bkld_state_t state;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic [1:0]  byte_idx;
    logic        read_dir;
    logic        matched;
    logic        sda_oe;
    logic        busy;
    logic [7:0]  index;
    logic [7:0]  control;
    logic [7:0]  configuration;
    logic [7:0]  boost;
    logic [7:0]  bright_a;
    logic [7:0]  bright_b;
    logic [7:0]  current_a;
    logic [7:0]  current_b;
    logic [7:0]  onoff_ramp;
    logic [7:0]  run_ramp;
    logic [7:0]  int_status;
    logic [7:0]  int_enable;
    logic [7:0]  fault_status;
    logic [7:0]  filter;
  } bkld_regs_t;

  bkld_regs_t r;
  bkld_regs_t next_r;

  logic       scl;
  logic       sda;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic [6:0] my_addr;
  logic [7:0] byte_in;
  logic [7:0] rd_val;

  assign scl        = r.scl_sync[1];
  assign sda        = r.sda_sync[1];
  assign scl_rise   = scl & ~r.scl_d;
  assign scl_fall   = ~scl & r.scl_d;
  assign start_seen = scl & r.scl_d & r.sda_d & ~sda;
  assign stop_seen  = scl & r.scl_d & ~r.sda_d & sda;
  assign my_addr    = I_ADDR_SEL ? ADDR_SEL_HIGH : ADDR_SEL_LOW;
  assign byte_in    = {r.shift[6:0], sda};

  // ==========================================================================
  // Read mux.
  // ==========================================================================
  // Read value for the current index; unmapped indices read zero.
  always_comb begin
    unique case (r.index)
      REG_CONTROL:       rd_val = r.control;
      REG_CONFIGURATION: rd_val = r.configuration;
      REG_BOOST:         rd_val = r.boost;
      REG_BRIGHT_A:      rd_val = r.bright_a;
      REG_BRIGHT_B:      rd_val = r.bright_b;
      REG_CURRENT_A:     rd_val = r.current_a;
      REG_CURRENT_B:     rd_val = r.current_b;
      REG_ONOFF_RAMP:    rd_val = r.onoff_ramp;
      REG_RUN_RAMP:      rd_val = r.run_ramp;
      REG_INT_STATUS:    rd_val = r.int_status;
      REG_INT_ENABLE:    rd_val = r.int_enable;
      REG_FAULT_STATUS:  rd_val = r.fault_status;
      REG_REVISION:      rd_val = REVISION_VALUE;
      REG_FILTER:        rd_val = r.filter;
      default:           rd_val = RST_ZERO;
    endcase
  end

  // ==========================================================================
  // Next state.
  // ==========================================================================
  // The pins are sampled through two flip-flops; edges are then found on
  // the second stage, so timing on the wires never reaches the logic raw.
  always_comb begin
    next_r          = r;
    next_r.scl_sync = {r.scl_sync[0], bus.scl};
    next_r.sda_sync = {r.sda_sync[0], bus.sda};
    next_r.scl_d    = scl;
    next_r.sda_d    = sda;
    next_r.hardware_enable_pin_q   = I_HARDWARE_ENABLE_PIN;
    // Sleep status simply follows the request one cycle later.
    next_r.control[CTL_SLEEP_STATUS] = r.control[CTL_SLEEP_CMD];
    if (r.wait_cnt != '0) begin
      next_r.wait_cnt = r.wait_cnt - 20'd1;
    end
    if (start_seen) begin
      next_r.busy     = 1'b1;
      next_r.state    = BKLD_BITS;
      next_r.bit_cnt  = '0;
      next_r.byte_idx = '0;
      next_r.matched  = 1'b0;
      next_r.sda_oe   = 1'b0;
    end else if (stop_seen) begin
      next_r.busy   = 1'b0;
      next_r.state  = BKLD_IDLE;
      next_r.sda_oe = 1'b0;
    end else begin
      unique case (r.state)
        BKLD_IDLE: begin
          next_r.sda_oe = 1'b0;
        end
        BKLD_BITS: begin
          if (scl_rise) begin
            next_r.shift   = byte_in;
            next_r.bit_cnt = r.bit_cnt + 4'd1;
          end
          if (scl_fall && r.bit_cnt == 4'd8) begin
            next_r.bit_cnt = '0;
            next_r.state   = BKLD_ACK;
            if (r.byte_idx == 2'd0) begin
              next_r.matched  = (r.shift[7:1] == my_addr) &&
                                (r.wait_cnt == '0);
              next_r.read_dir = r.shift[0];
              next_r.sda_oe   = (r.shift[7:1] == my_addr) &&
                                (r.wait_cnt == '0);
            end else if (r.matched) begin
              next_r.sda_oe = 1'b1;
              if (r.byte_idx == 2'd1) begin
                next_r.index = r.shift;
              end else begin
                next_r.index = r.index + 8'd1;
                unique case (r.index)
                  REG_CONTROL: begin
                    next_r.control = (r.shift & CTL_WRITE_MASK) |
                                     (r.control & ~CTL_WRITE_MASK);
                  end
                  REG_CONFIGURATION: next_r.configuration = r.shift;
                  REG_BOOST:         next_r.boost         = r.shift;
                  REG_BRIGHT_A: begin
                    if (!r.control[CTL_SLEEP_STATUS]) begin
                      next_r.bright_a = r.shift;
                    end
                  end
                  REG_BRIGHT_B: begin
                    if (!r.control[CTL_SLEEP_STATUS]) begin
                      next_r.bright_b = r.shift;
                    end
                  end
                  REG_CURRENT_A:    next_r.current_a    = r.shift;
                  REG_CURRENT_B:    next_r.current_b    = r.shift;
                  REG_ONOFF_RAMP:   next_r.onoff_ramp   = r.shift;
                  REG_RUN_RAMP:     next_r.run_ramp     = r.shift;
                  REG_INT_STATUS:   next_r.int_status   = r.shift;
                  REG_INT_ENABLE:   next_r.int_enable   = r.shift;
                  REG_FAULT_STATUS: next_r.fault_status = r.shift;
                  REG_FILTER:       next_r.filter       = r.shift;
                  default: begin
                  end
                endcase
              end
            end
          end
        end
        BKLD_ACK: begin
          // Release on the falling edge that ends the ninth pulse.
          if (scl_fall) begin
            next_r.sda_oe = 1'b0;
            if (!r.matched) begin
              next_r.state = BKLD_IDLE;
            end else if (r.read_dir && r.byte_idx == 2'd0) begin
              next_r.state  = BKLD_SEND;
              next_r.shift  = rd_val;
              next_r.sda_oe = ~rd_val[7];
            end else begin
              next_r.state = BKLD_BITS;
              if (r.byte_idx != 2'd2) begin
                next_r.byte_idx = r.byte_idx + 2'd1;
              end
            end
          end
        end
        BKLD_SEND: begin
          // data changes only after a falling clock edge.
          if (scl_fall) begin
            next_r.bit_cnt = r.bit_cnt + 4'd1;
            if (r.bit_cnt == 4'd7) begin
              next_r.sda_oe = 1'b0;
              next_r.state  = BKLD_RACK;
            end else begin
              next_r.shift  = {r.shift[6:0], 1'b0};
              next_r.sda_oe = ~r.shift[6];
            end
          end
        end
        BKLD_RACK: begin
          if (scl_rise) begin
            next_r.bit_cnt = '0;
            next_r.index   = r.index + 8'd1;
            next_r.state   = sda ? BKLD_IDLE : BKLD_ACK;
          end
        end
        default: next_r.state = BKLD_IDLE;
      endcase
    end
    // Software reset or a rising hardware enable restores defaults.
    if ((r.state == BKLD_BITS && scl_fall && r.bit_cnt == 4'd8 &&
         r.matched && r.byte_idx == 2'd2 && r.index == REG_SW_RESET &&
         r.shift[SWRST_BIT]) ||
        (I_HARDWARE_ENABLE_PIN && !r.hardware_enable_pin_q)) begin
      next_r.control       = RST_CONTROL;
      next_r.configuration = RST_CONFIGURATION;
      next_r.boost         = RST_BOOST;
      next_r.bright_a      = RST_ZERO;
      next_r.bright_b      = RST_ZERO;
      next_r.current_a     = RST_CURRENT;
      next_r.current_b     = RST_CURRENT;
      next_r.onoff_ramp    = RST_ZERO;
      next_r.run_ramp      = RST_ZERO;
      next_r.int_status    = RST_ZERO;
      next_r.int_enable    = RST_ZERO;
      next_r.fault_status  = RST_ZERO;
      next_r.filter        = RST_ZERO;
      next_r.wait_cnt      = 20'(WAIT_COUNT);
    end
  end

  // ==========================================================================
  // State register.
  // ==========================================================================
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      r               <= '0;
      r.scl_sync      <= 2'b11;
      r.sda_sync      <= 2'b11;
      r.scl_d         <= 1'b1;
      r.sda_d         <= 1'b1;
      r.wait_cnt      <= 20'(WAIT_COUNT);
      r.state         <= BKLD_IDLE;
      r.control       <= RST_CONTROL;
      r.configuration <= RST_CONFIGURATION;
      r.boost         <= RST_BOOST;
      r.current_a     <= RST_CURRENT;
      r.current_b     <= RST_CURRENT;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // Outputs, all from flip-flops.
  // ==========================================================================
  assign bus.sda_dev_oe           = r.sda_oe;
  assign O_STRING_A_OUTPUT_ENABLE = r.control[CTL_STRING_A_EN];
  assign O_STRING_B_OUTPUT_ENABLE = r.control[CTL_STRING_B_EN];
  assign O_SLEEP                  = r.control[CTL_SLEEP_STATUS];
  assign O_BUS_BUSY               = r.busy;

endmodule

// >>> design/bkl_host.sv
`timescale 1ns/100ps
// Controller end: runs one register write or one register read per command.
module bkl_host
  import bkl_pkg::*;
(
  input  wire logic       I_REF_CLK,
  input  wire logic       I_RST_N,
  input  wire logic [1:0] I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  output logic [31:0]     O_RDATA,
  bkl_if.host             bus
);

  typedef enum logic [1:0] {
    BKLH_IDLE = 2'b00,
    BKLH_RUN  = 2'b01,
    BKLH_STOP = 2'b11
  } bklh_state_t;

  typedef struct packed {
    logic [1:0]  sda_sync;
    bklh_state_t state;
    logic [9:0]  tick;
    logic [1:0]  phase;
    logic [6:0]  bitpos;
    logic [44:0] seq;
    logic [44:0] rx_mask;
    logic        scl_oe;
    logic        sda_oe;
    logic [7:0]  rdata;
    logic        nack;
    logic        done;
    logic [31:0] rd_out;
  } bklh_regs_t;

  bklh_regs_t r;
  bklh_regs_t next_r;
  logic [6:0] addr7;
  logic [7:0] idx;
  logic [7:0] dat;
  logic       rd_cmd;

  // Command word: [31] read, [30:24] address, [15:8] index, [7:0] data.
  assign rd_cmd = I_WDATA[31];
  assign addr7  = I_WDATA[30:24];
  assign idx    = I_WDATA[15:8];
  assign dat    = I_WDATA[7:0];

  // ==========================================================================
  // Next state.
  // ==========================================================================
  // Each bit takes four quarter phases: data set while clock is low, then
  // clock high, sample, clock low; start and stop use the same slots.
  always_comb begin
    next_r          = r;
    next_r.sda_sync = {r.sda_sync[0], bus.sda};
    next_r.rd_out   = '0;
    if (I_RD) begin
      unique case (I_ADDR)
        HOST_REG_STATUS: next_r.rd_out = {29'd0, r.nack, r.done,
                                          r.state != BKLH_IDLE};
        HOST_REG_RDATA:  next_r.rd_out = {24'd0, r.rdata};
        default:         next_r.rd_out = '0;
      endcase
    end
    unique case (r.state)
      BKLH_IDLE: begin
        if (I_WR && I_ADDR == HOST_REG_CMD) begin
          // start made with clock high, for writes and reads.
          next_r.sda_oe = 1'b1;
          next_r.state  = BKLH_RUN;
          next_r.tick   = '0;
          next_r.phase  = '0;
          next_r.bitpos = '0;
          next_r.done   = 1'b0;
          next_r.nack   = 1'b0;
          if (rd_cmd) begin
            next_r.seq     = {addr7, 1'b0, 1'b1, idx, 1'b1, 1'b1,
                              addr7, 1'b1, 1'b1, 8'hFF, 1'b1, 8'h0};
            // Bit 0 marks a read sequence for the whole transfer.
            next_r.rx_mask = 45'h0000_0000_0001;
          end else begin
            next_r.seq     = {addr7, 1'b0, 1'b1, idx, 1'b1, dat, 1'b1,
                              18'h0};
            next_r.rx_mask = '0;
          end
        end
      end
      BKLH_RUN: begin
        next_r.tick = r.tick + 10'd1;
        if (r.tick == 10'(SCL_HALF_CYCLES / 2)) begin
          next_r.tick  = '0;
          next_r.phase = r.phase + 2'd1;
          unique case (r.phase)
            2'd0: begin
              next_r.scl_oe = 1'b1;
              if (r.bitpos == 7'd18 && r.seq[26] == 1'b1 &&
                  r.rx_mask[0]) begin
                // Repeated start: release data before raising clock.
                next_r.sda_oe = 1'b0;
              end else begin
                next_r.sda_oe = ~r.seq[44];
              end
            end
            2'd1: next_r.scl_oe = 1'b0;
            2'd2: begin
              if (r.bitpos == 7'd18 && r.rx_mask[0]) begin
                next_r.sda_oe = 1'b1;  // repeated start.
              end
              // In a read, slot 26 is the direction bit, not an ack.
              if (r.bitpos == 7'd8 || r.bitpos == 7'd17 ||
                  (r.bitpos == 7'd26 && !r.rx_mask[0]) ||
                  (r.bitpos == 7'd27 && r.rx_mask[0])) begin
                next_r.nack = r.nack | r.sda_sync[1];
              end
              if (r.rx_mask[0] && r.bitpos >= 7'd28 &&
                  r.bitpos <= 7'd35) begin
                next_r.rdata = {r.rdata[6:0], r.sda_sync[1]};
              end
            end
            default: begin
              next_r.scl_oe = 1'b1;
              next_r.seq    = {r.seq[43:0], 1'b0};
              next_r.bitpos = r.bitpos + 7'd1;
              if ((!r.rx_mask[0] && r.bitpos == 7'd26) ||
                  (r.rx_mask[0] && r.bitpos == 7'd36)) begin
                next_r.state  = BKLH_STOP;
                next_r.sda_oe = 1'b1;
              end
            end
          endcase
        end
      end
      BKLH_STOP: begin
        // release clock, then data, freeing the bus.
        next_r.tick = r.tick + 10'd1;
        if (r.tick == 10'(SCL_HALF_CYCLES / 2)) begin
          next_r.scl_oe = 1'b0;
        end
        if (r.tick == 10'(SCL_HALF_CYCLES)) begin
          next_r.sda_oe = 1'b0;
          next_r.state  = BKLH_IDLE;
          next_r.done   = 1'b1;
        end
      end
      default: next_r.state = BKLH_IDLE;
    endcase
  end

  // ==========================================================================
  // State register.
  // ==========================================================================
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      r          <= '0;
      r.sda_sync <= 2'b11;
      r.state    <= BKLH_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign bus.scl_host_oe = r.scl_oe;
  assign bus.sda_host_oe = r.sda_oe;
  assign O_RDATA         = r.rd_out;

endmodule

// >>> verification/bkl_chk.sv
`timescale 1ns/100ps
// ========================================
// Link checker: watches both open-drain wires between the two ends.
module bkl_chk
  import bkl_pkg::*;
#(
  parameter int WAIT_COUNT = 200
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_host_oe,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe
);
  logic [3:0] pulses;
  logic [7:0] first;
  int         since_rst;

  // Clock rises since the last start, saturating so a long read never wraps.
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pulses    <= 4'h0;
      first     <= 8'h00;
      since_rst <= 0;
    end else begin
      if (since_rst < WAIT_COUNT) since_rst <= since_rst + 1;
      if ($fell(sda) && scl) pulses <= 4'h0;
      else if ($rose(scl) && pulses != 4'hF) pulses <= pulses + 4'h1;
      if ($rose(scl) && pulses < 4'h8) first <= {first[6:0], sda};
    end
  end

  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);

  sequence start_s; $fell(sda) && scl; endsequence
  sequence stop_s;  $rose(sda) && scl; endsequence
  // Ninth rise after a start closes the address byte.
  sequence ninth_s; $rose(scl) && pulses == 4'h8; endsequence

  a_dev_stable_high: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
    else $error("device moved data while clock high");
  a_start_by_host: assert property (start_s |-> $rose(sda_host_oe))
    else $error("start not made by controller");
  a_stop_by_host: assert property (stop_s |-> $fell(sda_host_oe) && !sda_dev_oe)
    else $error("stop not made by controller");
  a_ack_release: assert property (sda_dev_oe && scl |-> !sda_host_oe)
    else $error("controller held data during device slot");
  a_addr_no_drive: assert property ($rose(scl) && pulses < 4'h8 |-> !sda_dev_oe)
    else $error("device drove data inside address byte");
  // The bench ties the address select low, so only the low address matches.
  a_addr_ack: assert property (ninth_s and ##0 (first[7:1] == ADDR_SEL_LOW
    && since_rst >= WAIT_COUNT) |-> sda_dev_oe)
    else $error("own address not acknowledged");
  a_addr_nak: assert property (ninth_s and ##0 (first[7:1] != ADDR_SEL_LOW)
    |-> !sda_dev_oe)
    else $error("foreign address acknowledged");
  a_wait_nak: assert property (sda_dev_oe |-> since_rst >= WAIT_COUNT)
    else $error("device answered inside the wait period");
  a_idle_high: assert property (stop_s |=> (scl && sda) [*8])
    else $error("bus not left free after stop");
endmodule

// >>> verification/bkl_bench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
// ========================================
// Bench: host command port drives whole transfers to the device end.
module bkl_bench;
  import bkl_pkg::*;
  localparam int WAIT_TEST = 20000;
  logic        ref_clk;
  logic        rst_n;
  logic        wr;
  logic        rd;
  logic [1:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] s;
  logic [31:0] d;
  logic        a_en;
  logic        b_en;
  logic        sleep;
  logic        busy;
  int          fails;
  int          num_checks;

  bkl_if link();
  bkl_host bkl_host_inst (.I_REF_CLK(ref_clk), .I_RST_N(rst_n), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .bus(link.host));
  // Select and enable pins are held, so the low address is the live one.
  bkl_device #(.WAIT_COUNT(WAIT_TEST)) bkl_device_inst (.I_REF_CLK(ref_clk),
    .I_RST_N(rst_n), .I_ADDR_SEL(1'b0), .I_HARDWARE_ENABLE_PIN(1'b1),
    .bus(link.device), .O_STRING_A_OUTPUT_ENABLE(a_en),
    .O_STRING_B_OUTPUT_ENABLE(b_en), .O_SLEEP(sleep), .O_BUS_BUSY(busy));
  bkl_chk #(.WAIT_COUNT(WAIT_TEST)) bkl_chk_inst (.I_REF_CLK(ref_clk),
    .I_RST_N(rst_n), .scl(link.scl), .sda(link.sda),
    .scl_host_oe(link.scl_host_oe), .sda_host_oe(link.sda_host_oe),
    .sda_dev_oe(link.sda_dev_oe));

  // Free-running reference clock.
  always #2 ref_clk = ~ref_clk;

  // One-cycle strobes; read data is taken the cycle after the strobe only.
  task automatic reg_wr(input logic [1:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [1:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    @(posedge ref_clk);
    v = rdata;
  endtask

  // Issue one command, poll until idle, then check done and refusal bits.
  task automatic xfer(input logic [31:0] cmd, input logic nak,
                      output logic [31:0] v);
    int n;
    // Leave the bus free for a while after the previous stop.
    repeat (12) @(posedge ref_clk);
    reg_wr(HOST_REG_CMD, cmd);
    n = 0;
    do begin
      reg_rd(HOST_REG_STATUS, s);
      n++;
    end while (s[0] !== 1'b0 && n < 40000);
    `CHK(s[2:1], {nak, 1'b1})
    reg_rd(HOST_REG_RDATA, v);
  endtask

  task automatic wrap_up;
    $display("checks made %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence; each transfer costs some seven to ten thousand clocks.
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 2'h0;
    wdata = 32'h0000_0000;
    fails = 0;
    num_checks = 0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    xfer({1'b0, ADDR_SEL_LOW, 8'h00, REG_CONTROL, 8'h86}, 1'b1, d);
    $display("test early transfer refused done");
    repeat (WAIT_TEST) @(posedge ref_clk);
    xfer({1'b0, ADDR_SEL_LOW, 8'h00, REG_CONTROL, 8'h86}, 1'b0, d);
    `CHK({sleep, a_en, b_en}, 3'b111)
    $display("test control write done");
    xfer({1'b0, ADDR_SEL_HIGH, 8'h00, REG_BRIGHT_A, 8'h55}, 1'b1, d);
    $display("test foreign address done");
    xfer({1'b1, ADDR_SEL_LOW, 8'h00, REG_CONTROL, 8'h00}, 1'b0, d);
    `CHK(d[7:0], 8'hC6)
    `CHK(busy, 1'b0)
    $display("test control read back done");
    xfer({1'b0, ADDR_SEL_LOW, 8'h00, REG_BRIGHT_A, 8'h55}, 1'b0, d);
    xfer({1'b1, ADDR_SEL_LOW, 8'h00, REG_BRIGHT_A, 8'h00}, 1'b0, d);
    `CHK(d[7:0], 8'h00)
    $display("test brightness held while asleep done");
    wrap_up;
  end

  // Watchdog: the tests need some two hundred seventy microseconds.
  initial begin
    #400000;
    fails++;
    wrap_up;
  end
endmodule
